// file: src/ranger_defines.svh
`ifndef RANGER_DEFINES_SVH
`define RANGER_DEFINES_SVH

// ==========================================================
// timing
`define CLK_PERIOD_NS 10
`define MS_NS 1000000
`define S_NS 1000000000
`define TRIG_PULSE_NS 1000

// ==========================================================
// register offsets
`define ADDR_FAULT_MODE 8'h00
`define ADDR_TARGET_SEL 8'h04
`define ADDR_CALIB 8'h08
`define ADDR_TERM 8'h0c
`define ADDR_TRIG_IN 8'h10
`define ADDR_TRIG_OUT 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_FORMAT 8'h1c

// ==========================================================
// reset values and limits
`define RST_FAULT_MODE 2'h1
`define RST_CALIB 12'h001
`define RST_TERM 4'h0
`define TERM_MAX 4'h9
`define TRIG_DELAY_MAX 16'hea60

// ==========================================================
// field positions
`define DELAY_MSB 15
`define EDGE_LSB 16
`define EDGE_MSB 18
`define FMT_BIN_BIT 0
`define FMT_VAL_LSB 1
`define FMT_VAL_MSB 2
`define FMT_BLANK_BIT 3

// ==========================================================
// codes
`define EDGE_RISE 3'h0
`define EDGE_FALL 3'h1
`define EDGE_BOTH 3'h2
`define EDGE_AUTO_RISE 3'h3
`define EDGE_AUTO_FALL 3'h4
`define FAULT_HOLD 2'h0
`define FAULT_HIGH 2'h1
`define FAULT_LOW 2'h2
`define VAL_DIST 2'h0
`define VAL_STRENGTH 2'h1
`define VAL_TEMP 2'h2
`define VAL_ALL 2'h3
`define MARK_HI 1'b1
`define MARK_LO 1'b0

// ==========================================================
// terminator characters
`define CHR_CR 8'h0d
`define CHR_LF 8'h0a
`define CHR_STX 8'h02
`define CHR_ETX 8'h03
`define CHR_TAB 8'h09
`define CHR_SPACE 8'h20
`define CHR_COMMA 8'h2c
`define CHR_COLON 8'h3a
`define CHR_SEMI 8'h3b

`endif

// file: src/ranger_pkg.sv
package ranger_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01
    } tx_state_t;

    typedef enum logic [1:0] {
        LOOP_TRACK = 2'b00,
        LOOP_HOLD = 2'b01,
        LOOP_3MA = 2'b10,
        LOOP_21MA = 2'b11
    } loop_sel_t;

endpackage

// file: src/trig_delay_timer.sv
`timescale 1ns/1ps
`include "ranger_defines.svh"

module trig_delay_timer #(
    parameter int unsigned CYC_PER_MS = `MS_NS / `CLK_PERIOD_NS
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [15:0] delay_ms_i,
    output logic busy_o,
    output logic done_o
);

    logic [31:0] pre;
    logic [15:0] ms_cnt;
    logic [15:0] delay_q;

    // ==========================================================
    // millisecond delay, start ignored while busy
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            pre <= 32'h0;
            ms_cnt <= 16'h0;
            delay_q <= 16'h0;
        end else begin
            done_o <= 1'b0;
            if (!busy_o) begin
                if (start_i) begin // RULE14
                    busy_o <= 1'b1;
                    pre <= 32'h0;
                    ms_cnt <= 16'h0;
                    delay_q <= delay_ms_i;
                end
            end else if (pre == CYC_PER_MS - 1) begin
                pre <= 32'h0;
                ms_cnt <= ms_cnt + 16'h1;
                if (ms_cnt + 16'h1 == delay_q) begin // RULE14
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end else begin
                pre <= pre + 32'h1;
            end
        end
    end

    // ==========================================================
    // checks
    delay_span_a: assert property ( // RULE14
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(done_o) |-> $past(busy_o) && pre == 32'h0
    ) else $error("delay ended off a millisecond boundary");

endmodule

// file: src/ranger_output_trigger_ctl.sv
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ranger_defines.svh"

// Contract
// RULE1 - distance: high byte first, marks 1/0
// RULE2 - payload bits 6..0, 14-bit two's complement
// RULE3 - strength, temperature: one byte, bit7 zero
// RULE4 - fault mode drives switches and loop current
// RULE5 - target select: nearest or last target
// RULE6 - outside window: blank or error per choice
// RULE7 - periodic calibration, interval zero disables
// RULE8 - calibration drops at most one output
// RULE9 - ASCII line ends with selected terminator
// RULE10 - invalid terminator code keeps previous one
// RULE11 - trigger direction from delay/output settings
// RULE12 - host enables only trigger in or out
// RULE13 - trigger edge code selects sensitive edge
// RULE14 - configured delay before measurement start
// RULE15 - plain trigger starts one single measurement
// RULE16 - autotrigger toggles autostart mode per event
// RULE17 - delay applies before start and stop
// RULE18 - configuration through command register port
// RULE19 - binary errors sent as zero value
// RULE20 - trigger output pulses on chosen edge
// RULE21 - trigger input synchronised with two flops
module ranger_output_trigger_ctl
    import ranger_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `MS_NS / `CLK_PERIOD_NS,
    parameter int unsigned CYC_PER_S = `S_NS / `CLK_PERIOD_NS,
    parameter int unsigned PULSE_CYC = `TRIG_PULSE_NS / `CLK_PERIOD_NS,
    parameter int unsigned QDEPTH = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic meas_valid_i,
    input wire logic meas_fault_i,
    input wire logic [13:0] dist_first_i,
    input wire logic [13:0] dist_last_i,
    input wire logic win_first_i,
    input wire logic win_last_i,
    input wire logic [6:0] strength_i,
    input wire logic [6:0] temp_i,
    input wire logic ascii_line_end_i,
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic sw_a_level_i,
    input wire logic sw_b_level_i,
    input wire logic sw_a_inv_i,
    input wire logic sw_b_inv_i,
    output logic switch_out_a_o,
    output logic switch_out_b_o,
    output logic [1:0] current_loop_out_o,
    output logic [13:0] loop_dist_o,
    output logic calib_start_o,
    input wire logic calib_busy_i,
    input wire logic rate_high_i,
    input wire logic meas_start_i,
    input wire logic trig_in_i,
    output logic trig_o,
    output logic trig_oe_o,
    output logic single_measure_o,
    output logic autostart_mode_o
);

    logic [1:0] fault_output_mode;
    logic target_select;
    logic [11:0] calib_interval;
    logic [3:0] line_terminator_sel;
    logic [18:0] trig_in_config;
    logic [18:0] trig_out_config;
    logic [3:0] serial_format_sel;
    tx_state_t state;
    logic [2:0] cnt;
    logic [7:0] sh [0:QDEPTH-1];
    logic [7:0] next_bytes [0:QDEPTH-1];
    logic [2:0] next_cnt;
    logic [13:0] sel_dist;
    logic [13:0] out_dist;
    logic sel_in, fault, blank, drop, dropped;
    logic fmt_bin, load_bin, load_term, load;
    logic [1:0] val_set;
    logic [7:0] term_first;
    logic [31:0] sec_pre;
    logic [11:0] sec_cnt;
    logic trig_s1, trig_s2, trig_d;
    logic rise, fall, qual, in_mode, out_mode, trig_ev;
    logic [2:0] in_edge, out_edge;
    logic tmr_busy, tmr_done;
    logic [31:0] pulse_cnt;

    // ==========================================================
    // register writes
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            fault_output_mode <= `RST_FAULT_MODE;
            target_select <= 1'b0;
            calib_interval <= `RST_CALIB;
            line_terminator_sel <= `RST_TERM;
            trig_in_config <= 19'h0;
            trig_out_config <= 19'h0;
            serial_format_sel <= 4'h0;
        end else if (reg_wr_i) begin // RULE18
            case (reg_addr_i)
                `ADDR_FAULT_MODE: begin
                    fault_output_mode <= reg_wdata_i[1:0];
                end
                `ADDR_TARGET_SEL: begin
                    target_select <= reg_wdata_i[0];
                end
                `ADDR_CALIB: begin
                    calib_interval <= reg_wdata_i[11:0];
                end
                `ADDR_TERM: begin
                    if (reg_wdata_i[31:4] == 28'h0 &&
                        reg_wdata_i[3:0] <= `TERM_MAX) begin // RULE10
                        line_terminator_sel <= reg_wdata_i[3:0];
                    end
                end
                `ADDR_TRIG_IN: begin
                    if (reg_wdata_i[`DELAY_MSB:0] <= `TRIG_DELAY_MAX) begin
                        trig_in_config <= reg_wdata_i[18:0];
                    end
                end
                `ADDR_TRIG_OUT: begin
                    trig_out_config <= reg_wdata_i[18:0];
                end
                `ADDR_FORMAT: begin
                    serial_format_sel <= reg_wdata_i[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // register reads, one cycle later
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_FAULT_MODE: reg_rdata_o <= {30'h0, fault_output_mode};
                `ADDR_TARGET_SEL: reg_rdata_o <= {31'h0, target_select};
                `ADDR_CALIB: reg_rdata_o <= {20'h0, calib_interval};
                `ADDR_TERM: reg_rdata_o <= {28'h0, line_terminator_sel};
                `ADDR_TRIG_IN: reg_rdata_o <= {13'h0, trig_in_config};
                `ADDR_TRIG_OUT: reg_rdata_o <= {13'h0, trig_out_config};
                `ADDR_STATUS: begin
                    reg_rdata_o <= {23'h0, cnt, state, tmr_busy,
                        out_mode, in_mode, autostart_mode_o};
                end
                `ADDR_FORMAT: reg_rdata_o <= {28'h0, serial_format_sel};
                default: reg_rdata_o <= 32'h0;
            endcase
        end else begin
            reg_rdata_o <= 32'h0;
        end
    end

    // ==========================================================
    // measurement qualification
    assign fmt_bin = serial_format_sel[`FMT_BIN_BIT];
    assign val_set = serial_format_sel[`FMT_VAL_MSB:`FMT_VAL_LSB];
    assign sel_dist = target_select ? dist_last_i : dist_first_i; // RULE5
    assign sel_in = target_select ? win_last_i : win_first_i;
    assign fault = meas_fault_i ||
        (!sel_in && !serial_format_sel[`FMT_BLANK_BIT]); // RULE6
    assign blank = !meas_fault_i && !sel_in &&
        serial_format_sel[`FMT_BLANK_BIT]; // RULE6
    assign drop = calib_busy_i && rate_high_i && !dropped; // RULE8
    assign out_dist = fault ? 14'h0 : sel_dist; // RULE19
    assign load_bin = meas_valid_i && fmt_bin && !blank && !drop;
    assign load_term = ascii_line_end_i && !fmt_bin;
    assign load = load_bin || load_term;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dropped <= 1'b0;
        end else if (!calib_busy_i) begin
            dropped <= 1'b0;
        end else if (meas_valid_i && drop) begin
            dropped <= 1'b1; // RULE8
        end
    end

    // ==========================================================
    // switch and current loop outputs
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            switch_out_a_o <= 1'b0;
            switch_out_b_o <= 1'b0;
            current_loop_out_o <= LOOP_HOLD;
            loop_dist_o <= 14'h0;
        end else if (meas_valid_i) begin
            if (fault) begin // RULE4
                case (fault_output_mode)
                    `FAULT_HIGH: begin
                        switch_out_a_o <= ~sw_a_inv_i;
                        switch_out_b_o <= ~sw_b_inv_i;
                        current_loop_out_o <= LOOP_3MA;
                    end
                    `FAULT_LOW: begin
                        switch_out_a_o <= sw_a_inv_i;
                        switch_out_b_o <= sw_b_inv_i;
                        current_loop_out_o <= LOOP_21MA;
                    end
                    default: begin
                        current_loop_out_o <= LOOP_HOLD;
                    end
                endcase
            end else if (blank) begin
                current_loop_out_o <= LOOP_HOLD;
            end else begin
                switch_out_a_o <= sw_a_level_i;
                switch_out_b_o <= sw_b_level_i;
                current_loop_out_o <= LOOP_TRACK;
                loop_dist_o <= sel_dist;
            end
        end
    end

    // ==========================================================
    // byte framing
    always_comb begin
        case (line_terminator_sel) // RULE9
            4'h0: term_first = `CHR_CR;
            4'h1: term_first = `CHR_CR;
            4'h2: term_first = `CHR_LF;
            4'h3: term_first = `CHR_STX;
            4'h4: term_first = `CHR_ETX;
            4'h5: term_first = `CHR_TAB;
            4'h6: term_first = `CHR_SPACE;
            4'h7: term_first = `CHR_COMMA;
            4'h8: term_first = `CHR_COLON;
            default: term_first = `CHR_SEMI;
        endcase
    end

    always_comb begin
        for (int i = 0; i < QDEPTH; i++) begin
            next_bytes[i] = 8'h00;
        end
        if (fmt_bin) begin
            next_bytes[0] = {`MARK_HI, out_dist[13:7]}; // RULE1
            next_bytes[1] = {`MARK_LO, out_dist[6:0]}; // RULE2
            next_bytes[2] = (val_set == `VAL_TEMP) ?
                {`MARK_LO, temp_i} : {`MARK_LO, strength_i}; // RULE3
            next_bytes[3] = {`MARK_LO, temp_i}; // RULE3
            case (val_set)
                `VAL_DIST: next_cnt = 3'h2;
                `VAL_ALL: next_cnt = 3'h4;
                default: next_cnt = 3'h3;
            endcase
        end else begin
            next_bytes[0] = term_first;
            next_bytes[1] = `CHR_LF;
            next_cnt = (line_terminator_sel == 4'h0) ? 3'h2 : 3'h1;
        end
    end

    // ==========================================================
    // byte queue, drains to the serial line
    genvar gi;
    generate
        for (gi = 0; gi < QDEPTH; gi++) begin : g_q
            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    sh[gi] <= 8'h00;
                end else if (state == ST_IDLE && load) begin
                    sh[gi] <= next_bytes[gi];
                end else if (state == ST_SEND && tx_ready_i) begin
                    sh[gi] <= (gi == QDEPTH - 1) ? 8'h00 :
                        sh[(gi + 1) % QDEPTH];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            cnt <= 3'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (load) begin
                        state <= ST_SEND;
                        cnt <= next_cnt;
                    end
                end
                ST_SEND: begin
                    if (tx_ready_i) begin
                        cnt <= cnt - 3'h1;
                        if (cnt == 3'h1) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    cnt <= 3'h0;
                end
            endcase
        end
    end

    assign tx_valid_o = (state == ST_SEND);
    assign tx_data_o = sh[0];

    // ==========================================================
    // periodic calibration
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sec_pre <= 32'h0;
            sec_cnt <= 12'h0;
            calib_start_o <= 1'b0;
        end else begin
            calib_start_o <= 1'b0;
            if (calib_interval == 12'h0) begin // RULE7
                sec_pre <= 32'h0;
                sec_cnt <= 12'h0;
            end else if (sec_pre == CYC_PER_S - 1) begin
                sec_pre <= 32'h0;
                if (sec_cnt + 12'h1 >= calib_interval) begin
                    sec_cnt <= 12'h0;
                    calib_start_o <= 1'b1; // RULE7
                end else begin
                    sec_cnt <= sec_cnt + 12'h1;
                end
            end else begin
                sec_pre <= sec_pre + 32'h1;
            end
        end
    end

    // ==========================================================
    // trigger input
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_d <= 1'b0;
        end else begin
            trig_s1 <= trig_in_i; // RULE21
            trig_s2 <= trig_s1; // RULE21
            trig_d <= trig_s2;
        end
    end

    assign in_edge = trig_in_config[`EDGE_MSB:`EDGE_LSB];
    assign out_edge = trig_out_config[`EDGE_MSB:`EDGE_LSB];
    assign in_mode = trig_in_config[`DELAY_MSB:0] != 16'h0 &&
        trig_out_config[`DELAY_MSB:0] == 16'h0; // RULE11 RULE12
    assign out_mode = trig_in_config[`DELAY_MSB:0] == 16'h0 &&
        trig_out_config[`DELAY_MSB:0] != 16'h0; // RULE11 RULE12
    assign rise = trig_s2 && !trig_d;
    assign fall = !trig_s2 && trig_d;

    always_comb begin
        case (in_edge) // RULE13
            `EDGE_RISE: qual = rise;
            `EDGE_FALL: qual = fall;
            `EDGE_BOTH: qual = rise || fall;
            `EDGE_AUTO_RISE: qual = rise;
            `EDGE_AUTO_FALL: qual = fall;
            default: qual = 1'b0;
        endcase
    end

    assign trig_ev = in_mode && qual && !tmr_busy;

    trig_delay_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_delay (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .start_i(trig_ev),
        .delay_ms_i(trig_in_config[`DELAY_MSB:0]),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            single_measure_o <= 1'b0;
            autostart_mode_o <= 1'b0;
        end else begin
            single_measure_o <= 1'b0;
            if (tmr_done && in_mode) begin
                if (in_edge >= `EDGE_AUTO_RISE) begin
                    autostart_mode_o <= ~autostart_mode_o; // RULE16 RULE17
                end else begin
                    single_measure_o <= 1'b1; // RULE15
                end
            end
        end
    end

    // ==========================================================
    // trigger output to a second sensor
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pulse_cnt <= 32'h0;
            trig_o <= 1'b0;
            trig_oe_o <= 1'b0;
        end else begin
            trig_oe_o <= out_mode; // RULE11
            if (meas_start_i && out_mode && out_edge == `EDGE_BOTH) begin
                trig_o <= ~trig_o; // RULE20
            end else if (out_edge != `EDGE_BOTH) begin
                trig_o <= (pulse_cnt != 32'h0) ^
                    (out_edge == `EDGE_FALL); // RULE20
            end
            if (meas_start_i && out_mode) begin
                pulse_cnt <= PULSE_CYC;
            end else if (pulse_cnt != 32'h0) begin
                pulse_cnt <= pulse_cnt - 32'h1;
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    high_mark_a: assert property ( // RULE1
        state == ST_IDLE && load_bin |=> tx_valid_o && tx_data_o[7]
    ) else $error("binary high byte lacks its marker");

    low_mark_a: assert property ( // RULE2
        state == ST_IDLE && load_bin ##1 tx_ready_i |=>
        tx_valid_o && !tx_data_o[7]
    ) else $error("binary low byte marker not zero");

    error_zero_a: assert property ( // RULE19
        state == ST_IDLE && load_bin && fault |=>
        tx_data_o[6:0] == 7'h0 && sh[1][6:0] == 7'h0
    ) else $error("binary error not sent as zero");

    target_pick_a: assert property ( // RULE5
        state == ST_IDLE && load_bin && !fault |=>
        {tx_data_o[6:0], sh[1][6:0]} == $past(sel_dist)
    ) else $error("wrong target distance framed");

    fault_switch_a: assert property ( // RULE4
        meas_valid_i && fault && fault_output_mode == `FAULT_HIGH |=>
        switch_out_a_o == $past(~sw_a_inv_i) &&
        current_loop_out_o == LOOP_3MA
    ) else $error("fault mode one not applied");

    term_keep_a: assert property ( // RULE10
        reg_wr_i && reg_addr_i == `ADDR_TERM &&
        reg_wdata_i[3:0] > `TERM_MAX |=> $stable(line_terminator_sel)
    ) else $error("invalid terminator accepted");

    calib_off_a: assert property ( // RULE7
        calib_interval == 12'h0 ##1 calib_interval == 12'h0 |->
        !calib_start_o
    ) else $error("calibration while disabled");

    trig_dir_a: assert property ( // RULE11
        in_mode ##1 in_mode |-> !trig_oe_o
    ) else $error("trigger driven while in input mode");

    single_start_a: assert property ( // RULE15
        tmr_done && in_mode && in_edge < `EDGE_AUTO_RISE |=>
        single_measure_o && $stable(autostart_mode_o)
    ) else $error("plain trigger did not start one measure");

    auto_toggle_a: assert property ( // RULE16
        tmr_done && in_mode && in_edge >= `EDGE_AUTO_RISE |=>
        autostart_mode_o != $past(autostart_mode_o) && !single_measure_o
    ) else $error("autotrigger did not toggle");

    bin_all_c: cover property (
        state == ST_IDLE && load_bin && val_set == `VAL_ALL
    );
    auto_on_c: cover property ($rose(autostart_mode_o));
    crlf_c: cover property (
        state == ST_IDLE && load_term && line_terminator_sel == 4'h0
    );
    calib_drop_c: cover property (meas_valid_i && drop);

endmodule

// file: verif/serial_sink.sv
`timescale 1ns/1ps
module serial_sink (
    input wire logic sys_clk_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o
);
    logic [7:0] got[$];
    initial tx_ready_o = 1'b0;
    // stall every other cycle so held bytes are exercised
    always @(posedge sys_clk_i) begin
        if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
        tx_ready_o <= ~tx_ready_o;
    end
endmodule

// file: verif/test_ranger_output_trigger_ctl.sv
`timescale 1ns/1ps
module test_ranger_output_trigger_ctl;
    logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, meas_valid_i, meas_fault_i;
    logic [7:0] reg_addr_i, tx_data_o;
    logic [31:0] reg_wdata_i, reg_rdata_o, rv;
    logic [13:0] dist_first_i, dist_last_i, loop_dist_o;
    logic [6:0] strength_i, temp_i;
    logic [1:0] current_loop_out_o;
    logic win_first_i, win_last_i, ascii_line_end_i, tx_valid_o, tx_ready_i;
    logic sw_a, sw_b, sw_ai, sw_bi, calib_busy_i, rate_high_i, meas_start_i;
    logic trig_in_i, trig_o, trig_oe_o, single_measure_o, autostart_mode_o;
    logic sw_oa, cal;
    int bad_count = 0, cmp_count = 0, cyc = 0, k;
    logic [7:0] term_tab [10] = '{8'h0d, 8'h0d, 8'h0a, 8'h02, 8'h03,
        8'h09, 8'h20, 8'h2c, 8'h3a, 8'h3b};
    ranger_output_trigger_ctl #(.CYC_PER_MS(10), .CYC_PER_S(20)) DUT (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .meas_valid_i(meas_valid_i),
        .meas_fault_i(meas_fault_i), .dist_first_i(dist_first_i),
        .dist_last_i(dist_last_i), .win_first_i(win_first_i),
        .win_last_i(win_last_i), .strength_i(strength_i), .temp_i(temp_i),
        .ascii_line_end_i(ascii_line_end_i), .tx_data_o(tx_data_o),
        .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
        .sw_a_level_i(sw_a), .sw_b_level_i(sw_b), .sw_a_inv_i(sw_ai),
        .sw_b_inv_i(sw_bi), .switch_out_a_o(sw_oa), .switch_out_b_o(),
        .current_loop_out_o(current_loop_out_o), .loop_dist_o(loop_dist_o),
        .calib_start_o(cal), .calib_busy_i(calib_busy_i),
        .rate_high_i(rate_high_i), .meas_start_i(meas_start_i),
        .trig_in_i(trig_in_i), .trig_o(trig_o), .trig_oe_o(trig_oe_o),
        .single_measure_o(single_measure_o),
        .autostart_mode_o(autostart_mode_o));
    serial_sink sink (.sys_clk_i(sys_clk_i), .tx_data_i(tx_data_o),
        .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
    initial begin
        sys_clk_i = 0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        reg_rd_i <= 1; reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 0;
        #1 d = reg_rdata_o;
    endtask
    task automatic byte_is(input logic [7:0] e);
        for (k = 0; k < 50 && sink.got.size() == 0; k++) @(negedge sys_clk_i);
        chk("byte", {24'h0, e}, sink.got.size() ? sink.got.pop_front() : 'x);
    endtask
    task automatic meas(input logic f, input logic [13:0] d);
        @(posedge sys_clk_i);
        meas_valid_i <= 1; meas_fault_i <= f; dist_first_i <= d;
        @(posedge sys_clk_i);
        meas_valid_i <= 0;
        byte_is(f ? 8'h80 : {1'b1, d[13:7]});
        byte_is(f ? 8'h00 : {1'b0, d[6:0]});
    endtask
    task automatic trig_to(input logic lv);
        @(posedge sys_clk_i);
        trig_in_i <= lv;
        for (k = 0; k < 60 && single_measure_o !== 1'b1; k++)
            @(negedge sys_clk_i);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {reg_wr_i, reg_rd_i, meas_valid_i, meas_fault_i} = 0;
        win_first_i = 1;
        {win_last_i, ascii_line_end_i, sw_a, sw_b, sw_ai, sw_bi} = 0;
        {calib_busy_i, rate_high_i, meas_start_i, trig_in_i} = 0;
        {reg_addr_i, reg_wdata_i, dist_first_i, dist_last_i} = 0;
        {strength_i, temp_i} = 14'h05dd;
        rst_i = 1;
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 0;
        rd(8'h00, rv); chk("fault mode", 32'h1, rv);
        rd(8'h08, rv); chk("calib", 32'h1, rv);
        rd(8'h44, rv); chk("unmapped", 32'h0, rv);
        $display("registers done");
        wr(8'h1c, 32'h1);
        meas(0, 14'h1abc);
        chk("loop dist", 32'h1abc, loop_dist_o);
        meas(1, 14'h1abc);
        chk("fault out", 32'h5, {current_loop_out_o, sw_oa});
        wr(8'h1c, 32'h7);
        meas(0, 14'h0123);
        byte_is(8'h0b);
        byte_is(8'h5d);
        $display("binary done");
        wr(8'h1c, 32'h0);
        for (int i = 0; i < 11; i++) begin
            wr(8'h0c, i);
            @(posedge sys_clk_i);
            ascii_line_end_i <= 1;
            @(posedge sys_clk_i);
            ascii_line_end_i <= 0;
            byte_is(term_tab[i > 9 ? 9 : i]);
            if (i == 0) byte_is(8'h0a);
        end
        $display("terminator done");
        wr(8'h10, 32'h0000_0001);
        trig_to(1); chk("single", 15, k);
        wr(8'h10, 32'h0003_0001);
        trig_to(0);
        trig_to(1);
        chk("auto on", 1, autostart_mode_o);
        trig_to(0); chk("auto hold", 1, autostart_mode_o);
        trig_to(1); chk("auto off", 0, autostart_mode_o);
        $display("trigger done");
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h1);
        @(posedge sys_clk_i);
        meas_start_i <= 1;
        @(posedge sys_clk_i);
        meas_start_i <= 0;
        repeat (2) @(negedge sys_clk_i);
        chk("trig out", 32'h3, {trig_oe_o, trig_o});
        k = 0;
        repeat (40) @(negedge sys_clk_i) k += cal;
        chk("calib", 2, k);
        wr(8'h08, 32'h0);
        @(posedge sys_clk_i);
        k = 0;
        repeat (40) @(negedge sys_clk_i) k += cal;
        chk("calib off", 0, k);
        $display("output done");
        complete_run();
    end
endmodule
